// file: wwd_window_watchdog.v
// Functional notes
// - Key 0x00005AA5 reloads counter to 0x3F
// - Reload honoured only when count <= compare
// - Key written above compare requests chip reset
// - Control register accepts one write per reset
// - Bit 31 selects counting during debug
// - Prescale select picks divide 1 to 2048
// - Bit 1 enables compare interrupt
// - Bit 0 enables the watchdog counter
// - Reset flag sticky, survives reset, write-one-clears
// - Compare flag set on match, write-one-clears
// - Counter readback shows live count, read-only
// - Counter reads 0x3F after reset
// - Control resets to 0x003F_0800
// - Once enabled counter cannot be disabled; debug halt stops it unless bit 31 set
// - Interrupt asserts on match with enable
// - Reload takes effect after three watchdog clocks
// - Watchdog clock is sysclk/SYS_DIV (2048 by default); slow osc select (bit 12) is not writable, never set
`timescale 1ns/10ps
`include "wwd_regs.vh"
module wwd_window_watchdog #(
  parameter SYS_DIV = `WWD_SYS_DIV
)(
  input wire core_clk,
  input wire rst_b,
  input wire flag_rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire slow_osc_clk,
  input wire debug_halt,
  output reg compare_irq,
  output reg chip_reset_req
);
  reg [31:0] window_control;
  reg control_written;
  reg dog_reset_flag;
  reg compare_match_flag;
  reg [5:0] counter_value;
  reg ph_write;
  reg [11:0] ph_addr;
  reg [10:0] sys_div_cnt;
  reg [10:0] pre_cnt;
  reg [1:0] osc_sync;
  reg osc_prev;
  reg [1:0] reload_pipe;
  reg reload_pend;
  reg [10:0] next_pre_limit;
  // System divider terminal value
  localparam integer SYS_LAST = SYS_DIV - 1;
  // Writable control bits
  localparam [31:0] CTL_WRITE_MASK = 32'h803F0F03;
  wire [5:0] window_compare;
  wire [3:0] prescale_select;
  wire window_dog_enable;
  wire compare_irq_enable;
  wire debug_run_select;
  wire [10:0] sys_last;
  wire sys_tick;
  wire osc_tick;
  wire rd_take;
  wire clr_match;
  wire clr_reset;
  wire dog_fire;
  wire cmp_hit;
  wire src_tick;
  wire run;
  wire wd_tick;
  wire pre_tc;
  wire wr_key;
  wire key_ok;
  wire wr_ctl;
  wire wr_flg;
  wire early_reload;
  wire zero_reach;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Control field decode
  assign window_compare = window_control[`WWD_CTL_CMP_HI:`WWD_CTL_CMP_LO];
  assign prescale_select = window_control[`WWD_CTL_PSEL_HI:`WWD_CTL_PSEL_LO];
  assign window_dog_enable = window_control[`WWD_CTL_ENABLE];
  assign compare_irq_enable = window_control[`WWD_CTL_IRQ_EN];
  assign debug_run_select = window_control[`WWD_CTL_DEBUG_RUN];
  assign sys_last = SYS_LAST[10:0];
  assign sys_tick = (sys_div_cnt == sys_last);
  assign osc_tick = osc_sync[1] & ~osc_prev;
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  // Address phase capture
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
    end
    else if (hready)
    begin
      ph_write <= hsel & htrans[1] & hwrite;
      ph_addr <= haddr[11:0];
    end
  end

  // Read data mux
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      hrdata <= 32'h00000000;
    else if (rd_take)
    begin
      case ({haddr[11:2], 2'b00})
        `WWD_OFF_CONTROL: hrdata <= window_control;
        `WWD_OFF_FLAGS: hrdata <= {30'h00000000, dog_reset_flag, compare_match_flag};
        `WWD_OFF_COUNTER: hrdata <= {26'h0000000, counter_value};
        `WWD_OFF_RELOAD_KEY: hrdata <= 32'h00000000;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  assign wr_key = ph_write && (ph_addr == `WWD_OFF_RELOAD_KEY);
  assign wr_ctl = ph_write && (ph_addr == `WWD_OFF_CONTROL);
  assign wr_flg = ph_write && (ph_addr == `WWD_OFF_FLAGS);
  assign clr_match = wr_flg && hwdata[`WWD_FLG_MATCH];
  assign clr_reset = wr_flg && hwdata[`WWD_FLG_RESET];
  assign key_ok = wr_key && (hwdata == `WWD_RELOAD_KEY) && window_dog_enable;
  assign early_reload = key_ok && (counter_value > window_compare);

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      window_control <= `WWD_CONTROL_RESET;
      control_written <= 1'b0;
    end
    else if (wr_ctl && !control_written)
    begin
      window_control <= hwdata & CTL_WRITE_MASK;
      control_written <= 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sys_div_cnt <= 11'h000;
    else
      sys_div_cnt <= sys_tick ? 11'h000 : sys_div_cnt + 11'h001;
  end

  // Slow clock two-flop sync
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_sync <= 2'b00;
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_sync <= {osc_sync[0], slow_osc_clk};
      osc_prev <= osc_sync[1];
    end
  end
  assign src_tick = window_control[`WWD_CTL_PSEL_HI + 1] ? osc_tick : sys_tick;

  always @*
  begin
    next_pre_limit = 11'h000;
    case (prescale_select)
      4'h0: next_pre_limit = 11'd0;
      4'h1: next_pre_limit = 11'd1;
      4'h2: next_pre_limit = 11'd3;
      4'h3: next_pre_limit = 11'd7;
      4'h4: next_pre_limit = 11'd15;
      4'h5: next_pre_limit = 11'd31;
      4'h6: next_pre_limit = 11'd63;
      4'h7: next_pre_limit = 11'd127;
      4'h8: next_pre_limit = 11'd191;
      4'h9: next_pre_limit = 11'd255;
      4'hA: next_pre_limit = 11'd383;
      4'hB: next_pre_limit = 11'd511;
      4'hC: next_pre_limit = 11'd767;
      4'hD: next_pre_limit = 11'd1023;
      4'hE: next_pre_limit = 11'd1535;
      default: next_pre_limit = 11'd2047;
    endcase
  end

  assign run = window_dog_enable && (debug_run_select || !debug_halt);
  assign wd_tick = run && src_tick;
  assign pre_tc = wd_tick && (pre_cnt >= next_pre_limit);

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pre_cnt <= 11'h000;
    else if (pre_tc)
      pre_cnt <= 11'h000;
    else if (wd_tick)
      pre_cnt <= pre_cnt + 11'h001;
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reload_pend <= 1'b0;
      reload_pipe <= 2'b00;
    end
    else
    begin
      if (key_ok && !early_reload)
        reload_pend <= 1'b1;
      else if (wd_tick)
        reload_pend <= 1'b0;
      if (wd_tick)
        reload_pipe <= {reload_pipe[0], reload_pend};
    end
  end

  assign zero_reach = pre_tc && (counter_value == 6'h01) && !(reload_pipe[1] && wd_tick);
  // early key or zero fires reset
  assign dog_fire = zero_reach || early_reload;
  assign cmp_hit = window_dog_enable && (counter_value == window_compare);

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      counter_value <= `WWD_COUNT_TOP;
    else if (reload_pipe[1] && wd_tick)
      counter_value <= `WWD_COUNT_TOP;
    else if (pre_tc && counter_value != 6'h00)
      counter_value <= counter_value - 6'h01;
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      chip_reset_req <= 1'b0;
    else if (dog_fire)
      chip_reset_req <= 1'b1;
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      compare_match_flag <= 1'b0;
    else if (cmp_hit)
      compare_match_flag <= 1'b1;
    else if (clr_match)
      compare_match_flag <= 1'b0;
  end

  // sticky reset flag on own reset
  always @(posedge core_clk or negedge flag_rst_b)
  begin
    if (!flag_rst_b)
      dog_reset_flag <= 1'b0;
    else if (dog_fire)
      dog_reset_flag <= 1'b1;
    else if (clr_reset)
      dog_reset_flag <= 1'b0;
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      compare_irq <= 1'b0;
    else
      compare_irq <= compare_irq_enable && compare_match_flag;
  end
endmodule

// file: wwd_regs.vh
`ifndef WWD_REGS_VH
`define WWD_REGS_VH
`define WWD_OFF_RELOAD_KEY 12'h000
`define WWD_OFF_CONTROL 12'h004
`define WWD_OFF_FLAGS 12'h008
`define WWD_OFF_COUNTER 12'h00C
`define WWD_RELOAD_KEY 32'h00005AA5
`define WWD_COUNT_TOP 6'h3F
`define WWD_CONTROL_RESET 32'h003F0800
`define WWD_CTL_DEBUG_RUN 31
`define WWD_CTL_CMP_HI 21
`define WWD_CTL_CMP_LO 16
`define WWD_CTL_PSEL_HI 11
`define WWD_CTL_PSEL_LO 8
`define WWD_CTL_IRQ_EN 1
`define WWD_CTL_ENABLE 0
`define WWD_FLG_RESET 1
`define WWD_FLG_MATCH 0
`define WWD_SYS_DIV 2048
`define WWD_SYNC_CLOCKS 3
`endif

// file: wwd_asserts.sv
`timescale 1ns/10ps
module wwd_asserts (
  input wire core_clk,
  input wire rst_b,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire compare_irq,
  input wire chip_reset_req
);
  wire rd = hsel & hready & htrans[1] & ~hwrite;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("resp");
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_hold; chip_reset_req |=> chip_reset_req; endproperty
  a_hold: assert property (p_hold) else $error("req");
  property p_rel; $rose(rst_b) |-> !chip_reset_req && !compare_irq; endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_key; rd && haddr[7:0] == 8'h00 |=> hrdata == 32'h0; endproperty
  a_key: assert property (p_key) else $error("key");
  property p_cnt; rd && haddr[7:0] == 8'h0C |=> hrdata[31:6] == 26'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("cnt");
  property p_flg; rd && haddr[7:0] == 8'h08 |=> hrdata[31:2] == 30'h0; endproperty
  a_flg: assert property (p_flg) else $error("flg");
  property p_ctl; rd && haddr[7:0] == 8'h04 |=>
    {hrdata[30:22], hrdata[15:12], hrdata[7:2]} == 19'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  cover property (rd);
  cover property ($rose(chip_reset_req));
  cover property ($rose(compare_irq));
endmodule
bind wwd_window_watchdog wwd_asserts wwd_asserts_i (.core_clk(core_clk), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .compare_irq(compare_irq),
  .chip_reset_req(chip_reset_req));

// file: window_watchdog_timer_test.sv
`timescale 1ns/10ps
module window_watchdog_timer_test;
  reg core_clk = 0, rst_b = 0, flag_rst_b = 0, hsel = 0, hwrite = 0, debug_halt = 0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, q, v;
  integer miscompares = 0, check_count = 0, n;
  wire hready, compare_irq, chip_reset_req;
  wire [31:0] hrdata;
  always #2.5 core_clk = ~core_clk;
  wwd_window_watchdog #(.SYS_DIV(4)) wwd_window_watchdog_i (.core_clk(core_clk),
    .rst_b(rst_b), .flag_rst_b(flag_rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .slow_osc_clk(1'b0), .debug_halt(debug_halt),
    .compare_irq(compare_irq), .chip_reset_req(chip_reset_req));
  task cyc(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      q = hrdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task t_reset;
    begin
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h003F_0800);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h3F);
      rd(8'h10, 32'h0);
      bus(1'b1, 8'h0C, 32'h0);
      rd(8'h0C, 32'h3F);
    end
  endtask
  task t_early;
    begin
      bus(1'b1, 8'h04, 32'h8020_0003);
      bus(1'b1, 8'h04, 32'h0);
      rd(8'h04, 32'h8020_0003);
      bus(1'b1, 8'h00, 32'h0000_5AA5);
      cyc(2);
      chk({31'h0, chip_reset_req}, 32'h1);
      rd(8'h08, 32'h2);
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      cyc(1);
      rd(8'h08, 32'h2);
      bus(1'b1, 8'h08, 32'h2);
      rd(8'h08, 32'h0);
    end
  endtask
  task t_noirq;
    begin
      bus(1'b1, 8'h04, 32'h003E_0101);
      bus(1'b1, 8'h00, 32'h0000_5AA4);
      cyc(2);
      chk({31'h0, chip_reset_req}, 32'h0);
      bus(1'b0, 8'h0C, 32'h0);
      v = q;
      cyc(80);
      bus(1'b0, 8'h0C, 32'h0);
      v = v - q;
      chk({31'h0, v[5:0] > 6'h08 && v[5:0] < 6'h0C}, 32'h1);
      chk({31'h0, compare_irq}, 32'h0);
      rd(8'h08, 32'h1);
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      cyc(1);
    end
  endtask
  task t_window;
    begin
      bus(1'b1, 8'h04, 32'h003C_0003);
      for (n = 0; n < 100 && compare_irq !== 1'b1; n = n + 1) cyc(1);
      chk({31'h0, compare_irq}, 32'h1);
      rd(8'h08, 32'h1);
      bus(1'b1, 8'h00, 32'h0000_5AA5);
      q = 32'h0;
      for (n = 0; n < 20 && q[5:0] < 6'h3D; n = n + 1) bus(1'b0, 8'h0C, 32'h0);
      chk({31'h0, q[5:0] > 6'h3C}, 32'h1);
      chk({31'h0, chip_reset_req}, 32'h0);
      debug_halt <= 1'b1;
      cyc(4);
      bus(1'b0, 8'h0C, 32'h0);
      v = q;
      cyc(20);
      rd(8'h0C, v);
      debug_halt <= 1'b0;
      for (n = 0; n < 400 && chip_reset_req !== 1'b1; n = n + 1) cyc(1);
      chk({31'h0, chip_reset_req}, 32'h1);
      rd(8'h0C, 32'h0);
      rd(8'h08, 32'h3);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    cyc(12);
    rst_b <= 1'b1;
    flag_rst_b <= 1'b1;
    cyc(1);
    t_reset;
    t_early;
    t_noirq;
    t_window;
    print_verdict;
  end
  initial
  begin
    #30000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule
